/* design/asr_map.svh */
// Register offsets, field positions, reset values and serial codes of the status register block.
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_SEL_STATUS 3'h0
`define ASR_SEL_W 3
`define ASR_RW_SINGLE_WRITE 2'h0
`define ASR_RW_SINGLE_READ 2'h1
`define ASR_RW_CONT_START 2'h2
`define ASR_RW_CONT_STOP 2'h3
`define ASR_CMD_RW_HI 5
`define ASR_CMD_RW_LO 4
`define ASR_CMD_SEL_HI 2
`define ASR_CMD_SEL_LO 0
`define ASR_CMD_BODY_BITS 3'h7
`define ASR_STOP_CODE 8'h30
`define ASR_BYTE_BITS 4'h8
`define ASR_RDY_BIT 7
`define ASR_FILTER_SETTLED_FLAG_BIT 6
`define ASR_LPWR_BIT 5
`define ASR_MISSING_REFERENCE_FLAG_BIT 4
`define ASR_RST_READY 1'h1
`define ASR_RST_SETTLED 1'h1
`define ASR_RST_LPWR 1'h0
`define ASR_RST_MISSING_REFERENCE_FLAG 1'h0
`define ASR_RST_MODE_BITS 4'h0
`define ASR_WEN_ACTIVE 1'h0
`define ASR_SCLK_IDLE 1'h1
`endif

/* design/asr_pkg.sv */
// Types shared by the status register block.
package asr_pkg;
   typedef logic [7:0] asr_byte_t;
   typedef logic [3:0] asr_mode_bits_t;
   typedef logic [2:0] asr_sel_t;
   typedef logic [1:0] asr_rw_t;
   typedef enum logic [1:0] {
      ASR_WAIT_WEN,
      ASR_CMD_BODY,
      ASR_READ_ONE,
      ASR_READ_CONT
   } asr_port_state_t;
endpackage

/* design/asr_shift_out.sv */
// Byte shifter that drives the serial data output, most significant bit first.
`timescale 1ns/100ps
`include "asr_map.svh"
module asr_shift_out (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire asr_pkg::asr_byte_t load_data_i,
   input wire logic sclk_rise_i,
   input wire logic sclk_fall_i,
   output logic dout_o,
   output logic done_o
);
   import asr_pkg::*;

   asr_byte_t shift_q;
   logic [3:0] count_q;
   logic active_q;

   assign dout_o = shift_q[`ASR_RDY_BIT];
   assign done_o = active_q && sclk_rise_i && (count_q == `ASR_BYTE_BITS - 4'h1);

   // The next bit moves out on the falling edge so it is stable at the host's rising edge.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         shift_q <= 8'h00;
      end else if (load_i) begin
         shift_q <= load_data_i;
      end else if (active_q && sclk_fall_i && (count_q != 4'h0)) begin
         // Bit seven is already out after the load, so the first fall of a byte must not shift it away.
         shift_q <= {shift_q[6:0], 1'h0};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= 4'h0;
         active_q <= 1'h0;
      end else if (load_i) begin
         count_q <= 4'h0;
         active_q <= 1'h1;
      end else if (done_o) begin
         count_q <= 4'h0;
         active_q <= 1'h0;
      end else if (active_q && sclk_rise_i) begin
         count_q <= count_q + 4'h1;
      end
   end
endmodule

/* design/asr_status_register.sv */
// Converter status register with its three-wire serial read path.
// Functional notes
// - The status register is eight bits wide and read only, and no serial write can change it.
// - The register is shifted out bit seven first, down to bit zero.
// - After reset ready and settled read one, low power and missing reference read zero, low bits are open.
// - The ready flag always equals the active-low data-ready pin.
// - The settled flag is refreshed on each new filter result only while fast-settling mode is on.
// - In fast-settling mode early results from an unsettled second-stage filter keep settled high.
// - Those early results still pull the ready pin and flag low.
// - When the second-stage filter has settled, settled clears in the same update that lowers ready.
// - Without fast-settling mode ever used, settled clears at the first data read and stays so.
// - The command transfer mode selects single write, single read, start or stop of continuous read.
// - After a single read the port goes back to waiting for a command write.
// - Ready goes low on each data update and high again once the full result has been read.
`timescale 1ns/100ps
`include "asr_map.svh"
module asr_status_register (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic din_i,
   output logic dout_o,
   output logic ready_n_o,
   input wire logic data_update_i,
   input wire logic data_read_done_i,
   input wire logic fast_settling_mode_i,
   input wire logic filter_settled_i,
   input wire logic low_power_i,
   input wire logic missing_reference_i,
   input wire asr_pkg::asr_mode_bits_t mode_dependent_i,
   output logic other_cmd_o,
   output asr_pkg::asr_rw_t transfer_mode_field_o,
   output asr_pkg::asr_sel_t register_select_field_o,
   output asr_pkg::asr_port_state_t port_state_o
);
   import asr_pkg::*;

   function automatic logic is_status_read(input asr_rw_t rw, input asr_sel_t sel);
      is_status_read = (sel == `ASR_SEL_STATUS) &&
                       ((rw == `ASR_RW_SINGLE_READ) || (rw == `ASR_RW_CONT_START));
   endfunction

   logic sclk_q;
   logic sclk_rise;
   logic sclk_fall;
   asr_port_state_t state_q;
   logic [6:0] cmd_q;
   logic [2:0] cmd_count_q;
   asr_byte_t watch_q;
   logic ready_q;
   logic settled_q;
   logic fast_seen_q;
   logic low_power_flag;
   logic missing_reference_flag;
   asr_mode_bits_t mode_dependent_bits;
   asr_byte_t converter_status;
   logic cmd_done;
   logic load;
   logic shift_done;
   logic [6:0] cmd_full;
   asr_rw_t cmd_rw;
   asr_sel_t cmd_sel;

   // The serial clock is taken as synchronous, so one stage of history is enough for edges.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         // The serial clock idles high, so history starts high and no false rise follows reset.
         sclk_q <= `ASR_SCLK_IDLE;
      end else begin
         sclk_q <= sclk_i;
      end
   end
   assign sclk_rise = sclk_i && !sclk_q;
   assign sclk_fall = !sclk_i && sclk_q;

   assign cmd_full = {cmd_q[5:0], din_i};
   assign cmd_rw = cmd_full[`ASR_CMD_RW_HI:`ASR_CMD_RW_LO];
   assign cmd_sel = cmd_full[`ASR_CMD_SEL_HI:`ASR_CMD_SEL_LO];
   assign cmd_done = (state_q == ASR_CMD_BODY) && sclk_rise && (cmd_count_q == `ASR_CMD_BODY_BITS - 3'h1);
   assign load = (cmd_done && is_status_read(cmd_rw, cmd_sel)) ||
                 ((state_q == ASR_READ_CONT) && shift_done);

   // Incoming command bits, collected after a write-enable bit of zero.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_q <= 7'h00;
         cmd_count_q <= 3'h0;
      end else if (state_q == ASR_WAIT_WEN) begin
         cmd_count_q <= 3'h0;
      end else if ((state_q == ASR_CMD_BODY) && sclk_rise) begin
         cmd_q <= cmd_full;
         cmd_count_q <= cmd_count_q + 3'h1;
      end
   end

   // In continuous read the input line is still watched for the stop code.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         watch_q <= 8'h00;
      end else if (state_q != ASR_READ_CONT) begin
         watch_q <= 8'h00;
      end else if (sclk_rise) begin
         watch_q <= {watch_q[6:0], din_i};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ASR_WAIT_WEN;
      end else begin
         case (state_q)
            ASR_WAIT_WEN: begin
               if (sclk_rise && (din_i == `ASR_WEN_ACTIVE)) begin
                  state_q <= ASR_CMD_BODY;
               end
            end
            ASR_CMD_BODY: begin
               if (cmd_done) begin
                  if (is_status_read(cmd_rw, cmd_sel) && (cmd_rw == `ASR_RW_CONT_START)) begin
                     state_q <= ASR_READ_CONT;
                  end else if (is_status_read(cmd_rw, cmd_sel)) begin
                     state_q <= ASR_READ_ONE;
                  end else begin
                     // Writes, stop codes and other registers are handed on; status is never written.
                     state_q <= ASR_WAIT_WEN;
                  end
               end
            end
            ASR_READ_ONE: begin
               if (shift_done) begin
                  state_q <= ASR_WAIT_WEN;
               end
            end
            ASR_READ_CONT: begin
               if (sclk_rise && ({watch_q[6:0], din_i} == `ASR_STOP_CODE)) begin
                  state_q <= ASR_WAIT_WEN;
               end
            end
            default: begin
               state_q <= ASR_WAIT_WEN;
            end
         endcase
      end
   end

   // Pulse and fields for the neighbouring register blocks that own the other selections.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         other_cmd_o <= 1'h0;
         transfer_mode_field_o <= `ASR_RW_SINGLE_WRITE;
         register_select_field_o <= `ASR_SEL_STATUS;
      end else begin
         other_cmd_o <= cmd_done && !is_status_read(cmd_rw, cmd_sel);
         if (cmd_done) begin
            transfer_mode_field_o <= cmd_rw;
            register_select_field_o <= cmd_sel;
         end
      end
   end

   // Ready: an update wins over a read completing in the same cycle, so no result is lost.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ready_q <= `ASR_RST_READY;
      end else if (data_update_i) begin
         ready_q <= 1'h0;
      end else if (data_read_done_i) begin
         ready_q <= 1'h1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fast_seen_q <= 1'h0;
      end else if (fast_settling_mode_i) begin
         fast_seen_q <= 1'h1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         settled_q <= `ASR_RST_SETTLED;
      end else if (data_update_i && fast_settling_mode_i) begin
         // High for early results, low in the very update that lowers ready.
         settled_q <= !filter_settled_i;
      end else if (data_read_done_i && !fast_seen_q && !fast_settling_mode_i) begin
         settled_q <= 1'h0;
      end
   end

   // Live flags are registered so a byte read never sees a half-changed value.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         low_power_flag <= `ASR_RST_LPWR;
         missing_reference_flag <= `ASR_RST_MISSING_REFERENCE_FLAG;
         mode_dependent_bits <= `ASR_RST_MODE_BITS;
      end else begin
         low_power_flag <= low_power_i;
         missing_reference_flag <= missing_reference_i;
         mode_dependent_bits <= mode_dependent_i;
      end
   end

   always_comb begin
      converter_status = {4'h0, mode_dependent_bits};
      converter_status[`ASR_RDY_BIT] = ready_q;
      converter_status[`ASR_FILTER_SETTLED_FLAG_BIT] = settled_q;
      converter_status[`ASR_LPWR_BIT] = low_power_flag;
      converter_status[`ASR_MISSING_REFERENCE_FLAG_BIT] = missing_reference_flag;
   end

   assign ready_n_o = ready_q;
   assign port_state_o = state_q;

   asr_shift_out u_shift (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .load_i(load),
      .load_data_i(converter_status),
      .sclk_rise_i(sclk_rise),
      .sclk_fall_i(sclk_fall),
      .dout_o(dout_o),
      .done_o(shift_done)
   );
endmodule

/* tb/asr_status_register_properties.sv */
// Port assertions for the status register block.
`timescale 1ns/100ps
`include "asr_map.svh"
module asr_status_register_properties
   import asr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic dout_o,
   input wire logic ready_n_o,
   input wire logic data_update_i,
   input wire logic data_read_done_i,
   input wire logic other_cmd_o,
   input wire asr_rw_t transfer_mode_field_o,
   input wire asr_sel_t register_select_field_o,
   input wire asr_port_state_t port_state_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   chk_ready_update: assert property (
      data_update_i |=> !ready_n_o) else $error("ready not low after update");
   chk_ready_release: assert property (
      data_read_done_i && !data_update_i |=> ready_n_o) else $error("ready not high after read");
   chk_ready_low_hold: assert property (
      !ready_n_o && !data_read_done_i |=> !ready_n_o) else $error("ready rose with no read");
   chk_ready_high_hold: assert property (
      ready_n_o && !data_update_i |=> ready_n_o) else $error("ready fell with no update");
   chk_reset_values: assert property (
      $fell(rst_i) |-> ready_n_o && !dout_o) else $error("wrong values after reset");
   chk_single_read_cmd: assert property (
      port_state_o == ASR_READ_ONE |-> transfer_mode_field_o == `ASR_RW_SINGLE_READ)
      else $error("single read with wrong mode");
   chk_cont_read_cmd: assert property (
      port_state_o == ASR_READ_CONT |-> transfer_mode_field_o == `ASR_RW_CONT_START)
      else $error("continuous read with wrong mode");
   chk_other_not_status: assert property (
      other_cmd_o |-> !(register_select_field_o == `ASR_SEL_STATUS && transfer_mode_field_o
      inside {`ASR_RW_SINGLE_READ, `ASR_RW_CONT_START})) else $error("status read flagged as other");
   chk_single_return: assert property (
      port_state_o == ASR_READ_ONE ##1 port_state_o != ASR_READ_ONE |-> port_state_o == ASR_WAIT_WEN)
      else $error("single read did not return to wait");
   cover property (data_update_i);
   cover property (port_state_o == ASR_READ_CONT);
   cover property (other_cmd_o);
endmodule

/* tb/asr_host_model.sv */
// Host model that clocks bytes over the three-wire serial port.
`timescale 1ns/100ps
module asr_host_model (
   input wire logic clock_i,
   input wire logic dout_i,
   output logic sclk_o,
   output logic din_o
);
   int half = 2;
   initial begin
      sclk_o = 1'h1;
      din_o = 1'h1;
   end
   // The serial clock stands high between frames; data is taken at each rise.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(negedge clock_i);
         sclk_o = 1'h0;
         din_o = tx[i];
         repeat (half) @(negedge clock_i);
         rx[i] = dout_i;
         sclk_o = 1'h1;
         repeat (half) @(negedge clock_i);
      end
      // A released line must not keep showing the last bit.
      din_o = ~din_o;
   endtask
endmodule

/* tb/tb_asr_status_register.sv */
// Self-checking bench for the status register block.
`timescale 1ns/100ps
module tb_asr_status_register;
   import asr_pkg::*;
   logic clock_i, rst_i, sclk_i, din_i, dout_o, ready_n_o, other_cmd_o;
   logic data_update_i, data_read_done_i, fast_settling_mode_i, filter_settled_i;
   logic low_power_i, missing_reference_i;
   asr_mode_bits_t mode_dependent_i;
   asr_rw_t transfer_mode_field_o;
   asr_sel_t register_select_field_o;
   asr_port_state_t port_state_o;
   asr_byte_t rx;
   int n_mismatch = 0;
   int n_tests = 0;
   asr_status_register dut_u (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk_i), .din_i(din_i),
      .dout_o(dout_o), .ready_n_o(ready_n_o), .data_update_i(data_update_i),
      .data_read_done_i(data_read_done_i), .fast_settling_mode_i(fast_settling_mode_i),
      .filter_settled_i(filter_settled_i), .low_power_i(low_power_i),
      .missing_reference_i(missing_reference_i), .mode_dependent_i(mode_dependent_i),
      .other_cmd_o(other_cmd_o), .transfer_mode_field_o(transfer_mode_field_o),
      .register_select_field_o(register_select_field_o), .port_state_o(port_state_o));
   asr_host_model host_u (.clock_i(clock_i), .dout_i(dout_o), .sclk_o(sclk_i), .din_o(din_i));
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic status(input logic [7:0] exp);
      host_u.xfer(8'h10, rx);
      host_u.xfer(8'h00, rx);
      cmp("status", exp, rx);
   endtask
   task automatic pulse(input logic upd);
      @(negedge clock_i);
      data_update_i = upd;
      data_read_done_i = ~upd;
      @(negedge clock_i);
      data_update_i = 1'h0;
      data_read_done_i = 1'h0;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic sc_reset();
      status(8'hc0);
      cmp("state", 8'(ASR_WAIT_WEN), 8'(port_state_o));
      cmp("ready pin", 8'h1, 8'(ready_n_o));
   endtask
   // A write command followed by all ones must leave the status alone; a read elsewhere is only handed on.
   task automatic sc_write();
      host_u.xfer(8'h00, rx);
      cmp("mode field", 8'h0, 8'(transfer_mode_field_o));
      host_u.xfer(8'hff, rx);
      status(8'hc0);
      host_u.xfer(8'h11, rx);
      cmp("select field", 8'h1, 8'(register_select_field_o));
      cmp("state", 8'(ASR_WAIT_WEN), 8'(port_state_o));
   endtask
   task automatic sc_nofast();
      pulse(1'h1);
      cmp("ready pin", 8'h0, 8'(ready_n_o));
      status(8'h40);
      pulse(1'h0);
      status(8'h80);
      pulse(1'h1);
      pulse(1'h0);
      status(8'h80);
   endtask
   task automatic sc_fast();
      fast_settling_mode_i = 1'h1;
      pulse(1'h1);
      status(8'h40);
      filter_settled_i = 1'h1;
      pulse(1'h1);
      status(8'h00);
      pulse(1'h0);
      status(8'h80);
   endtask
   // Slow host, continuous read of two bytes, the second carrying the stop code.
   task automatic sc_cont();
      low_power_i = 1'h1;
      missing_reference_i = 1'h1;
      mode_dependent_i = 4'h5;
      host_u.half = 5;
      host_u.xfer(8'h20, rx);
      cmp("state", 8'(ASR_READ_CONT), 8'(port_state_o));
      cmp("mode field", 8'h2, 8'(transfer_mode_field_o));
      host_u.xfer(8'h00, rx);
      cmp("cont status", 8'hb5, rx);
      host_u.xfer(8'h30, rx);
      cmp("cont status", 8'hb5, rx);
      cmp("state", 8'(ASR_WAIT_WEN), 8'(port_state_o));
   endtask
   initial begin
      clock_i = 1'h0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial begin
      rst_i = 1'h1;
      {data_update_i, data_read_done_i, fast_settling_mode_i, filter_settled_i} = 4'h0;
      {low_power_i, missing_reference_i, mode_dependent_i} = 6'h00;
      repeat (10) @(negedge clock_i);
      rst_i = 1'h0;
      sc_reset();
      sc_write();
      sc_nofast();
      sc_fast();
      sc_cont();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      give_verdict();
   end
endmodule
bind asr_status_register asr_status_register_properties chk_u (.clock_i(clock_i), .rst_i(rst_i),
   .dout_o(dout_o), .ready_n_o(ready_n_o), .data_update_i(data_update_i),
   .data_read_done_i(data_read_done_i), .other_cmd_o(other_cmd_o),
   .transfer_mode_field_o(transfer_mode_field_o), .register_select_field_o(register_select_field_o),
   .port_state_o(port_state_o));
